// [common/ost_ctl_if.sv]
// Control and status bundle between the register slave and the counter core.
`timescale 1ns/10ps
`default_nettype none
interface ost_ctl_if;
  logic                               start;
  logic                               stop;
  logic                               ctl_load;
  ost_pkg::ost_mode_t                 mode;
  logic                               start_irq_en;
  logic [ost_pkg::DATA_W-1:0]         compare;
  logic [ost_pkg::DATA_W-1:0]         count;
  logic                               enabled;
  logic                               irq;

  modport regs (output start, output stop, output ctl_load, output mode,
                output start_irq_en, output compare,
                input count, input enabled, input irq);
  modport core (input start, input stop, input ctl_load, input mode,
                input start_irq_en, input compare,
                output count, output enabled, output irq);
endinterface
`default_nettype wire

// [common/ost_pkg.sv]
// Constants, types and decode helper for the interval / free-run timer.
`default_nettype none
package ost_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_START   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STOP    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h20;

  // Field positions
  localparam int unsigned TRIG_BIT = 0;
  localparam int unsigned SIE_BIT  = 0;
  localparam int unsigned MODE_BIT = 1;

  // Reset and initial values
  localparam logic [DATA_W-1:0] COMPARE_RST   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CNT_INIT_INTV = 32'hFFFF_FFFF;
  localparam logic [DATA_W-1:0] CNT_INIT_FREE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ONE_WORD      = 32'h0000_0001;

  // Operating mode; first member is the reset mode
  typedef enum logic {OST_INTERVAL, OST_FREERUN} ost_mode_t;

  // Register hit on the exact byte address, low bits included
  function automatic logic ost_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] ofs);
    ost_hit = (addr == ofs);
  endfunction

endpackage
`default_nettype wire

// [dv/tb_ost_timer.sv]
// Self-checking testbench for the interval / free-run timer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module tb_ost_timer;
  logic                        pclk;
  logic                        presetn;
  logic                        psel;
  logic                        penable;
  logic                        pwrite;
  logic [ost_pkg::ADDR_W-1:0]  paddr;
  logic [ost_pkg::DATA_W-1:0]  pwdata;
  logic [ost_pkg::DATA_W-1:0]  prdata;
  logic                        pready;
  logic                        pslverr;
  logic                        timer_irq;
  int                          err_count = 0;
  int                          tests_run = 0;
  int                          cyc = 0;
  int                          e_edge;
  int                          i_edge;
  int                          p_edge;
  int                          s;
  integer                      seed = 32'h6840;
  logic [31:0]                 rd;
  logic [31:0]                 held;
  logic [31:0]                 cmp;
  logic [31:0]                 cmp2;
  logic                        rerr;

  ost_timer ost_timer_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .timer_irq (timer_irq)
  );

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Edge count lets interrupt timing be measured against the write edge
  always @(posedge pclk) cyc <= cyc + 1;

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One APB transfer; data taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(negedge pclk);
    end
    if (n >= 50)
      err_count++;
    @(posedge pclk);
    rd      = prdata;
    rerr    = pslverr;
    e_edge  = cyc;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Edge index that launched the next interrupt pulse
  task automatic wait_irq();
    int n;
    n = 0;
    p_edge = i_edge;
    @(negedge pclk);
    while (timer_irq !== 1'b1 && n < 3000)
    begin
      n++;
      @(negedge pclk);
    end
    if (n >= 3000)
      err_count++;
    i_edge = cyc - 1;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    end_sim();
  end

  initial
  begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ost_pkg::OFS_COUNTER, 32'h0000_0000);
    `CHK(rd, ost_pkg::CNT_INIT_INTV)
    apb(1'b0, ost_pkg::OFS_ENABLE, 32'h0000_0000);
    `CHK(rd, ost_pkg::ZERO_WORD)
    apb(1'b0, 8'h24, 32'h0000_0000);
    `CHK(rerr, 1'b1)
    $display("reset and map test done");
    cmp = 32'd10 + ($random(seed) & 32'h0000_000F);
    apb(1'b1, ost_pkg::OFS_COMPARE, cmp);
    apb(1'b1, ost_pkg::OFS_START, ost_pkg::ONE_WORD);
    s = e_edge;
    apb(1'b0, ost_pkg::OFS_ENABLE, 32'h0000_0000);
    `CHK(rd, ost_pkg::ONE_WORD)
    wait_irq();
    `CHK(32'(i_edge - s), cmp + 32'd1)
    @(negedge pclk);
    `CHK(timer_irq, 1'b0)
    cmp2 = 32'd10 + ($random(seed) & 32'h0000_000F);
    apb(1'b1, ost_pkg::OFS_COMPARE, cmp2);
    wait_irq();
    `CHK(32'(i_edge - p_edge), cmp + 32'd1)
    wait_irq();
    `CHK(32'(i_edge - p_edge), cmp2 + 32'd1)
    apb(1'b1, ost_pkg::OFS_CONTROL, 32'h0000_0003);
    apb(1'b0, ost_pkg::OFS_CONTROL, 32'h0000_0000);
    `CHK(rd, ost_pkg::ZERO_WORD)
    apb(1'b1, ost_pkg::OFS_STOP, ost_pkg::ONE_WORD);
    apb(1'b0, ost_pkg::OFS_ENABLE, 32'h0000_0000);
    `CHK(rd, ost_pkg::ZERO_WORD)
    apb(1'b0, ost_pkg::OFS_COUNTER, 32'h0000_0000);
    held = rd;
    repeat (30) @(posedge pclk);
    apb(1'b0, ost_pkg::OFS_COUNTER, 32'h0000_0000);
    `CHK(rd, held)
    `CHK(timer_irq, 1'b0)
    $display("interval basic test done");
    apb(1'b1, ost_pkg::OFS_CONTROL, ost_pkg::ONE_WORD);
    apb(1'b0, ost_pkg::OFS_CONTROL, 32'h0000_0000);
    `CHK(rd, ost_pkg::ONE_WORD)
    apb(1'b1, ost_pkg::OFS_START, ost_pkg::ONE_WORD);
    s = e_edge;
    wait_irq();
    `CHK(32'(i_edge - s), 32'd0)
    wait_irq();
    `CHK(32'(i_edge - p_edge), cmp2 + 32'd1)
    repeat (3) @(posedge pclk);
    apb(1'b1, ost_pkg::OFS_START, ost_pkg::ONE_WORD);
    s = e_edge;
    wait_irq();
    `CHK(32'(i_edge - s), 32'd0)
    wait_irq();
    `CHK(32'(i_edge - p_edge), cmp2 + 32'd1)
    $display("restart test done");
    apb(1'b1, ost_pkg::OFS_STOP, ost_pkg::ONE_WORD);
    apb(1'b1, ost_pkg::OFS_COMPARE, ost_pkg::ZERO_WORD);
    apb(1'b1, ost_pkg::OFS_START, ost_pkg::ONE_WORD);
    repeat (3) @(posedge pclk);
    for (int k = 0; k < 8; k++)
    begin
      @(negedge pclk);
      `CHK(timer_irq, 1'b1)
    end
    apb(1'b1, ost_pkg::OFS_STOP, ost_pkg::ONE_WORD);
    @(negedge pclk);
    `CHK(timer_irq, 1'b0)
    apb(1'b0, ost_pkg::OFS_COUNTER, 32'h0000_0000);
    `CHK(rd, ost_pkg::ZERO_WORD)
    $display("zero compare interval test done");
    cmp = 32'd20 + ($random(seed) & 32'h0000_001F);
    apb(1'b1, ost_pkg::OFS_COMPARE, cmp);
    apb(1'b1, ost_pkg::OFS_CONTROL, 32'h0000_0002);
    apb(1'b0, ost_pkg::OFS_COUNTER, 32'h0000_0000);
    `CHK(rd, ost_pkg::CNT_INIT_FREE)
    apb(1'b1, ost_pkg::OFS_START, ost_pkg::ONE_WORD);
    s = e_edge;
    // Second start must not reload; raised compare must take effect at once
    apb(1'b1, ost_pkg::OFS_START, ost_pkg::ONE_WORD);
    cmp2 = cmp + 32'd8 + ($random(seed) & 32'h0000_0007);
    apb(1'b1, ost_pkg::OFS_COMPARE, cmp2);
    wait_irq();
    `CHK(32'(i_edge - s), cmp2 + 32'd1)
    apb(1'b1, ost_pkg::OFS_STOP, ost_pkg::ONE_WORD);
    apb(1'b1, ost_pkg::OFS_START, ost_pkg::ONE_WORD);
    s = e_edge;
    wait_irq();
    `CHK(32'(i_edge - s), cmp2 + 32'd1)
    $display("free-run test done");
    apb(1'b1, ost_pkg::OFS_STOP, ost_pkg::ONE_WORD);
    apb(1'b1, ost_pkg::OFS_COMPARE, ost_pkg::ZERO_WORD);
    apb(1'b1, ost_pkg::OFS_CONTROL, 32'h0000_0003);
    apb(1'b1, ost_pkg::OFS_START, ost_pkg::ONE_WORD);
    for (int k = 0; k < 3; k++)
    begin
      @(negedge pclk);
      `CHK(timer_irq, (k < 2))
    end
    $display("zero compare free-run test done");
    end_sim();
  end
endmodule
`default_nettype wire

// [hdl/ost_core.sv]
// Counter core: interval down-count with reload, free-run up-count with match.
`timescale 1ns/10ps
`default_nettype none
module ost_core (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control and status
  ost_ctl_if.core   tif
);

  logic                        intv;
  logic [ost_pkg::DATA_W-1:0]  next_count;
  logic                        next_irq;

  assign intv = (tif.mode == ost_pkg::OST_INTERVAL);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tif.enabled <= 1'b0;
    else if (tif.start)
      tif.enabled <= 1'b1;
    else if (tif.stop)
      tif.enabled <= 1'b0;
  end

  always_comb
  begin
    next_count = tif.count;
    next_irq   = 1'b0;
    if (tif.start && (!tif.enabled || intv))
    begin
      // Fresh start, or forced restart in interval mode
      next_count = intv ? tif.compare : ost_pkg::CNT_INIT_FREE;
      next_irq   = tif.start_irq_en;
    end
    else if (tif.stop)
    begin
      // Hold count; irq drops, which ends the zero-compare level
      next_count = tif.count;
    end
    else if (tif.ctl_load)
    begin
      next_count = intv ? ost_pkg::CNT_INIT_INTV : ost_pkg::CNT_INIT_FREE;
    end
    else if (tif.enabled && intv)
    begin
      if (tif.count == ost_pkg::ZERO_WORD)
      begin
        // Compare sampled only here and on start, so mid-run rewrites wait for zero or a restart
        next_count = tif.compare;
        next_irq   = 1'b1;
      end
      else
        next_count = tif.count - ost_pkg::ONE_WORD;
    end
    else if (tif.enabled)
    begin
      // Wraps naturally through the full range
      next_count = tif.count + ost_pkg::ONE_WORD;
      next_irq   = (tif.count == tif.compare);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tif.count <= ost_pkg::CNT_INIT_INTV;
    else
      tif.count <= next_count;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tif.irq <= 1'b0;
    else
      tif.irq <= next_irq;
  end

endmodule
`default_nettype wire

// [hdl/ost_timer.sv]
// Operating-system timer top: APB register slave, core instance and checks.
`timescale 1ns/10ps
`default_nettype none
module ost_timer (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ost_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [ost_pkg::DATA_W-1:0]  pwdata,
  output var  logic [ost_pkg::DATA_W-1:0]  prdata,
  output var  logic                        pready,
  output var  logic                        pslverr,
  // Interrupt request
  output var  logic                        timer_irq
);

  ost_ctl_if tif ();

  logic                        access;
  logic                        wr;
  logic                        mapped;
  logic                        wr_start;
  logic                        wr_stop;
  logic                        wr_ctl;
  logic                        mode_select_bit;
  logic                        start_irq_enable_bit;
  logic [ost_pkg::DATA_W-1:0]  compare_value;
  logic [ost_pkg::DATA_W-1:0]  next_rdata;

  // One wait state keeps read data and pready both registered
  assign access = psel && penable && pready;
  assign wr     = access && pwrite;
  assign mapped = ost_pkg::ost_hit(paddr, ost_pkg::OFS_COMPARE)
               || ost_pkg::ost_hit(paddr, ost_pkg::OFS_COUNTER)
               || ost_pkg::ost_hit(paddr, ost_pkg::OFS_ENABLE)
               || ost_pkg::ost_hit(paddr, ost_pkg::OFS_START)
               || ost_pkg::ost_hit(paddr, ost_pkg::OFS_STOP)
               || ost_pkg::ost_hit(paddr, ost_pkg::OFS_CONTROL);

  assign wr_start = wr && ost_pkg::ost_hit(paddr, ost_pkg::OFS_START)
                    && pwdata[ost_pkg::TRIG_BIT];
  assign wr_stop  = wr && ost_pkg::ost_hit(paddr, ost_pkg::OFS_STOP)
                    && pwdata[ost_pkg::TRIG_BIT];
  // Control is locked while the counter runs
  assign wr_ctl   = wr && ost_pkg::ost_hit(paddr, ost_pkg::OFS_CONTROL)
                    && !tif.enabled;

  // Trigger bits are never stored, so they read back as zero at once
  assign tif.start        = wr_start;
  assign tif.stop         = wr_stop;
  assign tif.mode         = mode_select_bit ? ost_pkg::OST_FREERUN
                                            : ost_pkg::OST_INTERVAL;
  assign tif.start_irq_en = start_irq_enable_bit;
  assign tif.compare      = compare_value;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && penable && !pready;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && penable && !pready && !mapped;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      compare_value <= ost_pkg::COMPARE_RST;
    else if (wr && ost_pkg::ost_hit(paddr, ost_pkg::OFS_COMPARE))
      compare_value <= pwdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_select_bit      <= 1'b0;
      start_irq_enable_bit <= 1'b0;
    end
    else if (wr_ctl)
    begin
      mode_select_bit      <= pwdata[ost_pkg::MODE_BIT];
      start_irq_enable_bit <= pwdata[ost_pkg::SIE_BIT];
    end
  end

  // Counter takes the new mode's initial value once the mode bit has settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tif.ctl_load <= 1'b0;
    else
      tif.ctl_load <= wr_ctl;
  end

  always_comb
  begin
    next_rdata = ost_pkg::ZERO_WORD;
    if (ost_pkg::ost_hit(paddr, ost_pkg::OFS_COMPARE))
      next_rdata = compare_value;
    else if (ost_pkg::ost_hit(paddr, ost_pkg::OFS_COUNTER))
      next_rdata = tif.count;
    else if (ost_pkg::ost_hit(paddr, ost_pkg::OFS_ENABLE))
      next_rdata[ost_pkg::TRIG_BIT] = tif.enabled;
    else if (ost_pkg::ost_hit(paddr, ost_pkg::OFS_CONTROL))
    begin
      next_rdata[ost_pkg::MODE_BIT] = mode_select_bit;
      next_rdata[ost_pkg::SIE_BIT]  = start_irq_enable_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= ost_pkg::ZERO_WORD;
    else if (psel && penable && !pready && !pwrite)
      prdata <= next_rdata;
  end

  ost_core ost_core_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .tif     (tif.core)
  );

  // Core irq is already a flip-flop
  assign timer_irq = tif.irq;

  logic intv;
  assign intv = (tif.mode == ost_pkg::OST_INTERVAL);

  start_sets_en_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.start |=> tif.enabled)
    else $error("start did not set enabled flag");

  stop_clears_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.stop |=> !tif.enabled && !timer_irq)
    else $error("stop did not clear enabled flag or irq");

  hold_stopped_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !tif.enabled && !tif.start && !tif.ctl_load |=> $stable(tif.count))
    else $error("stopped counter changed");

  intv_down_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.enabled && intv && !tif.start && !tif.stop
    && tif.count != ost_pkg::ZERO_WORD
    |=> tif.count == $past(tif.count) - ost_pkg::ONE_WORD)
    else $error("interval counter did not count down");

  intv_reload_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.enabled && intv && !tif.start && !tif.stop
    && tif.count == ost_pkg::ZERO_WORD
    |=> tif.count == $past(tif.compare) && timer_irq)
    else $error("interval reload at zero missing");

  intv_period_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.enabled && intv && !tif.start && !tif.stop && !tif.ctl_load
    && tif.count == 32'h0000_0003 && tif.compare != ost_pkg::ZERO_WORD
    ##1 (!tif.start && !tif.stop)[*3]
    |=> timer_irq)
    else $error("interval irq not after count reached zero");

  intv_restart_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.start && intv |=> tif.count == $past(tif.compare))
    else $error("interval start did not reload compare");

  start_irq_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.start && tif.start_irq_en && (intv || !tif.enabled) |=> timer_irq)
    else $error("start irq missing");

  zero_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.enabled && intv && tif.compare == ost_pkg::ZERO_WORD
    && tif.count == ost_pkg::ZERO_WORD && !tif.stop
    |=> timer_irq && tif.count == ost_pkg::ZERO_WORD)
    else $error("zero compare irq not held");

  free_up_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.enabled && !intv && !tif.stop
    |=> tif.count == $past(tif.count) + ost_pkg::ONE_WORD)
    else $error("free-run counter did not count up");

  free_match_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.enabled && !intv && !tif.stop && tif.count == tif.compare |=> timer_irq)
    else $error("free-run match irq missing");

  free_nomatch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.enabled && !intv && !tif.start && tif.count != tif.compare |=> !timer_irq)
    else $error("free-run irq without match");

  free_zero_start_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.start && !intv && !tif.enabled |=> tif.count == ost_pkg::CNT_INIT_FREE)
    else $error("free-run start not from zero");

  free_ignore_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.start && !intv && tif.enabled
    |=> tif.count == $past(tif.count) + ost_pkg::ONE_WORD)
    else $error("free-run restart not ignored");

  merge_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.start && !intv && !tif.enabled && tif.start_irq_en
    && tif.compare == ost_pkg::ZERO_WORD
    ##1 (tif.compare == ost_pkg::ZERO_WORD && !tif.stop)
    |-> timer_irq ##1 timer_irq)
    else $error("merged start and match irq not two cycles");

  ctl_lock_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    tif.enabled |=> $stable(mode_select_bit) && $stable(start_irq_enable_bit))
    else $error("control changed while enabled");

  irq_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    timer_irq && tif.enabled && intv && !tif.start
    && tif.count != ost_pkg::ZERO_WORD
    |=> !timer_irq)
    else $error("interval irq longer than one cycle");

  bus_answer_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable ##1 psel && penable |=> pready)
    else $error("APB answer not after one wait state");

endmodule
`default_nettype wire
